// *** src/pdsc_pkg.sv ***
// Constants shared by the synthesizer control logic: serial word layout,
// divider widths, prescaler moduli and values after reset.
// Assumes a single 200 MHz system clock samples all pins.
package pdsc_pkg;
   localparam int unsigned SR_LEN_WIDE     = 19;
   localparam int unsigned SR_LEN_NARROW   = 17;
   localparam int unsigned FB_BITS         = 18;
   localparam int unsigned REF_BITS        = 15;
   localparam int unsigned REF_CNT_BITS    = 16;
   localparam int unsigned SWALLOW_BITS    = 5;
   localparam int unsigned MAIN_BITS       = 13;
   localparam int unsigned PRE_BITS        = 6;
   // Bit positions in the serial word, counted from its LSB
   localparam int unsigned POS_TARGET      = 0;
   localparam int unsigned POS_TEST        = 1;
   localparam int unsigned POS_RANGE       = 2;
   localparam int unsigned POS_LOCK_EN     = 3;
   localparam int unsigned POS_REF_LSB     = 4;
   localparam int unsigned POS_FB_LSB      = 1;
   // Reference "multiple" mode divides by the programmed value times 8
   localparam int unsigned REF_MULT_SHIFT  = 3;
   // Dual-modulus prescaler terminal counts (31 and 32, for moduli 32 and 33)
   localparam logic [5:0]  PRE_LAST_LOW    = 6'h1f;
   localparam logic [5:0]  PRE_LAST_HIGH   = 6'h20;
   // Values after reset
   localparam logic [17:0] RST_FB_WORD     = 18'h00420;
   localparam logic [14:0] RST_REF         = 15'h0800;
   localparam logic        RST_RANGE       = 1'b0;
   localparam logic        RST_LOCK_EN     = 1'b0;
   localparam logic        RST_TEST        = 1'b0;
   typedef enum logic [1:0] {
      PDSC_PD_IDLE,
      PDSC_PD_UP,
      PDSC_PD_DOWN
   } pdsc_pd_state_t;
endpackage

// *** src/pdsc_top.sv ***
// Serial-programmed divider, phase detector and lock logic of a pager PLL.
// Assumes every pin input (serial port, oscillator, VCO, straps) is asynchronous
// to ref_clk_in and toggles well below a quarter of its rate.
`timescale 1ns/10ps
module pdsc_top
   import pdsc_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic reset_in,
   // Serial programming port
   input  wire logic ser_clk_in,
   input  wire logic ser_data_in,
   input  wire logic ser_latch_en_in,
   // Mode pins
   input  wire logic divider_width_select_in,
   input  wire logic battery_save_n_in,
   input  wire logic fast_lock_control_in,
   input  wire logic test_in,
   // Frequency inputs
   input  wire logic ref_osc_in,
   input  wire logic vco_in,
   // Phase detector and pump
   output logic      phase_pump_up_out,
   output logic      phase_pump_down_out,
   output logic      phase_pump_oe_n_out,
   output logic      pump_boost_out,
   // Lock detect and boost
   output logic      lock_detect_out,
   output logic      lock_detect_oe_n_out,
   output logic      boost_out
);
   import pdsc_pkg::*;

   function automatic logic rise(input logic prev, input logic cur);
      return cur & ~prev;
   endfunction

   // Two-stage synchronisers; stage one is read only by stage two
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] sync_prev_reg;
   logic [7:0] pins;
   assign pins = {vco_in, ref_osc_in, test_in, fast_lock_control_in,
                  battery_save_n_in, divider_width_select_in, ser_latch_en_in, ser_clk_in};

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_reg     <= 8'h00;
         sync2_reg     <= 8'h00;
         sync_prev_reg <= 8'h00;
      end else begin
         sync1_reg     <= pins;
         sync2_reg     <= sync1_reg;
         sync_prev_reg <= sync2_reg;
      end
   end

   logic data1_reg;
   logic data2_reg;
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         data1_reg <= 1'b0;
         data2_reg <= 1'b0;
      end else begin
         data1_reg <= ser_data_in;
         data2_reg <= data1_reg;
      end
   end

   logic sclk_rise;
   logic latch_rise;
   logic wide;
   logic running;
   logic fast_lock;
   logic test_pin;
   logic ref_rise;
   logic vco_rise;
   assign sclk_rise  = rise(sync_prev_reg[0], sync2_reg[0]);
   assign latch_rise = rise(sync_prev_reg[1], sync2_reg[1]);
   assign wide       = ~sync2_reg[2];
   assign running    = sync2_reg[3];
   assign fast_lock  = sync2_reg[4];
   assign test_pin   = sync2_reg[5];
   assign ref_rise   = rise(sync_prev_reg[6], sync2_reg[6]);
   assign vco_rise   = rise(sync_prev_reg[7], sync2_reg[7]);

   // Shift register and latches
   logic [18:0] shift_reg,   shift_next;
   logic [17:0] fb_word_reg, fb_word_next;
   logic [14:0] ref_val_reg, ref_val_next;
   logic        range_reg,   range_next;
   logic        lock_en_reg, lock_en_next;
   logic        test_bit_reg, test_bit_next;
   logic        fb_load_reg, fb_load_next;
   logic [18:0] word;

   always_comb begin
      shift_next    = shift_reg;
      fb_word_next  = fb_word_reg;
      ref_val_next  = ref_val_reg;
      range_next    = range_reg;
      lock_en_next  = lock_en_reg;
      test_bit_next = test_bit_reg;
      fb_load_next  = 1'b0;
      // Narrow words sit in the low 17 bits; upper stages are ignored
      word = wide ? shift_reg : {2'b00, shift_reg[16:0]};
      if (sclk_rise) begin
         shift_next = {shift_reg[17:0], data2_reg};
      end
      if (latch_rise) begin
         if (word[POS_TARGET]) begin
            ref_val_next  = word[18:POS_REF_LSB];
            range_next    = word[POS_RANGE];
            lock_en_next  = word[POS_LOCK_EN];
            test_bit_next = word[POS_TEST];
         end else begin
            fb_word_next = word[18:POS_FB_LSB];
            fb_load_next = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         shift_reg    <= 19'h00000;
         fb_word_reg  <= RST_FB_WORD;
         ref_val_reg  <= RST_REF;
         range_reg    <= RST_RANGE;
         lock_en_reg  <= RST_LOCK_EN;
         test_bit_reg <= RST_TEST;
         fb_load_reg  <= 1'b0;
      end else begin
         shift_reg    <= shift_next;
         fb_word_reg  <= fb_word_next;
         ref_val_reg  <= ref_val_next;
         range_reg    <= range_next;
         lock_en_reg  <= lock_en_next;
         test_bit_reg <= test_bit_next;
         fb_load_reg  <= fb_load_next;
      end
   end

   // Reference divider
   logic [15:0] ref_cnt_reg, ref_cnt_next;
   logic        ref_pulse_reg, ref_pulse_next;
   logic [15:0] ref_ratio;
   assign ref_ratio = range_reg ? {1'b0, ref_val_reg}
                                : {ref_val_reg[12:0], 3'b000};

   always_comb begin
      ref_cnt_next   = ref_cnt_reg;
      ref_pulse_next = 1'b0;
      if (!running) begin
         ref_cnt_next = 16'h0000;
      end else if (ref_rise) begin
         if (ref_cnt_reg + 16'h0001 >= ref_ratio) begin
            ref_cnt_next   = 16'h0000;
            ref_pulse_next = 1'b1;
         end else begin
            ref_cnt_next = ref_cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ref_cnt_reg   <= 16'h0000;
         ref_pulse_reg <= 1'b0;
      end else begin
         ref_cnt_reg   <= ref_cnt_next;
         ref_pulse_reg <= ref_pulse_next;
      end
   end

   // Feedback divider: prescaler runs at 33 while swallow count remains
   logic [5:0]  pre_cnt_reg,  pre_cnt_next;
   logic [4:0]  swal_reg,     swal_next;
   logic [12:0] main_reg,     main_next;
   logic        fb_pulse_reg, fb_pulse_next;
   logic [12:0] main_val;
   logic [4:0]  swal_val;
   logic [5:0]  pre_last;
   assign main_val = wide ? fb_word_reg[17:5] : {2'b00, fb_word_reg[15:5]};
   assign swal_val = fb_word_reg[4:0];
   assign pre_last = (swal_reg != 5'h00) ? PRE_LAST_HIGH : PRE_LAST_LOW;

   always_comb begin
      pre_cnt_next  = pre_cnt_reg;
      swal_next     = swal_reg;
      main_next     = main_reg;
      fb_pulse_next = 1'b0;
      // A new word restarts the cycle so a stale count never runs on
      if (!running || fb_load_reg) begin
         pre_cnt_next = 6'h00;
         swal_next    = swal_val;
         main_next    = main_val;
      end else if (vco_rise) begin
         if (pre_cnt_reg >= pre_last) begin
            pre_cnt_next = 6'h00;
            if (swal_reg != 5'h00) begin
               swal_next = swal_reg - 5'h01;
            end
            if (main_reg <= 13'h0001) begin
               main_next     = main_val;
               swal_next     = swal_val;
               fb_pulse_next = 1'b1;
            end else begin
               main_next = main_reg - 13'h0001;
            end
         end else begin
            pre_cnt_next = pre_cnt_reg + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pre_cnt_reg  <= 6'h00;
         swal_reg     <= 5'h00;
         main_reg     <= 13'h0000;
         fb_pulse_reg <= 1'b0;
      end else begin
         pre_cnt_reg  <= pre_cnt_next;
         swal_reg     <= swal_next;
         main_reg     <= main_next;
         fb_pulse_reg <= fb_pulse_next;
      end
   end

   // Tri-state phase frequency detector and outputs
   pdsc_pd_state_t pd_reg, pd_next;
   logic up_next;
   logic down_next;
   logic pump_oe_n_next;
   logic boost_drv_next;
   logic lock_next;
   logic lock_oe_n_next;
   logic flag_next;
   logic test_mode;
   assign test_mode = test_pin | test_bit_reg;

   always_comb begin
      pd_next = pd_reg;
      case (pd_reg)
         PDSC_PD_IDLE: begin
            if (ref_pulse_reg && !fb_pulse_reg) begin
               pd_next = PDSC_PD_UP;
            end else if (fb_pulse_reg && !ref_pulse_reg) begin
               pd_next = PDSC_PD_DOWN;
            end
         end
         PDSC_PD_UP: begin
            if (fb_pulse_reg) begin
               pd_next = PDSC_PD_IDLE;
            end
         end
         PDSC_PD_DOWN: begin
            if (ref_pulse_reg) begin
               pd_next = PDSC_PD_IDLE;
            end
         end
         default: pd_next = PDSC_PD_IDLE;
      endcase
      if (!running) begin
         pd_next = PDSC_PD_IDLE;
      end
      up_next        = (pd_next == PDSC_PD_UP);
      down_next      = (pd_next == PDSC_PD_DOWN);
      pump_oe_n_next = ~(up_next | down_next);
      // Lock status is high while no error pulse is open
      lock_next      = ~(up_next | down_next);
      lock_oe_n_next = ~lock_en_reg;
      boost_drv_next = fast_lock;
      if (test_mode) begin
         lock_next      = ref_pulse_reg;
         lock_oe_n_next = 1'b0;
         boost_drv_next = fb_pulse_reg;
      end else if (!lock_en_reg) begin
         lock_next = 1'b0;
      end
      flag_next = fast_lock;
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pd_reg               <= PDSC_PD_IDLE;
         phase_pump_up_out    <= 1'b0;
         phase_pump_down_out  <= 1'b0;
         phase_pump_oe_n_out  <= 1'b1;
         pump_boost_out       <= 1'b0;
         lock_detect_out      <= 1'b0;
         lock_detect_oe_n_out <= 1'b1;
         boost_out            <= 1'b0;
      end else begin
         pd_reg               <= pd_next;
         phase_pump_up_out    <= up_next;
         phase_pump_down_out  <= down_next;
         phase_pump_oe_n_out  <= pump_oe_n_next;
         pump_boost_out       <= flag_next;
         lock_detect_out      <= lock_next;
         lock_detect_oe_n_out <= lock_oe_n_next;
         boost_out            <= boost_drv_next;
      end
   end

endmodule // pdsc_top

// *** verif/pdsc_top_sva.sv ***
// Concurrent checks on the pins of the synthesizer control block.
// Assumes one ref_clk domain and pins held a few cycles around each change.
`timescale 1ns/10ps
module pdsc_top_sva (
   // Clock, reset and mode pins
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic battery_save_n_in,
   input wire logic fast_lock_control_in,
   input wire logic test_in,
   // Outputs watched
   input wire logic phase_pump_up_out,
   input wire logic phase_pump_down_out,
   input wire logic phase_pump_oe_n_out,
   input wire logic pump_boost_out,
   input wire logic lock_detect_out,
   input wire logic lock_detect_oe_n_out,
   input wire logic boost_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   wire logic pump_on = phase_pump_up_out || phase_pump_down_out;
   // Pin changes take a few cycles through the synchronisers
   sequence s_fast_lock_steady;
      $stable(fast_lock_control_in) [*8];
   endsequence
   // Test pin held with the dividers running: lock pin shows reference pulses, boost pin feedback pulses
   sequence s_test_run;
      (test_in && battery_save_n_in) [*6];
   endsequence
   sequence s_normal;
      (!test_in) [*8];
   endsequence
   property p_pump_boost;
      s_fast_lock_steady |-> pump_boost_out == fast_lock_control_in;
   endproperty
   a_pump_boost: assert property (p_pump_boost) else $error("pump boost off its pin");
   property p_boost;
      (s_fast_lock_steady and s_normal) |-> boost_out == fast_lock_control_in;
   endproperty
   a_boost: assert property (p_boost) else $error("boost off its pin");
   property p_pump_excl;
      !(phase_pump_up_out && phase_pump_down_out);
   endproperty
   a_pump_excl: assert property (p_pump_excl) else $error("pump up and down together");
   property p_pump_oe;
      phase_pump_oe_n_out == !pump_on;
   endproperty
   a_pump_oe: assert property (p_pump_oe) else $error("pump enable wrong");
   property p_lock_off;
      lock_detect_oe_n_out |-> !lock_detect_out;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("disabled lock output high");
   property p_save;
      (!battery_save_n_in) [*6] |-> phase_pump_oe_n_out;
   endproperty
   a_save: assert property (p_save) else $error("pump driven in standby");
   property p_test_oe;
      test_in [*6] |-> !lock_detect_oe_n_out;
   endproperty
   a_test_oe: assert property (p_test_oe) else $error("lock output off in test");
   property p_lock_err;
      (!test_in) [*4] ##0 pump_on |-> !lock_detect_out;
   endproperty
   a_lock_err: assert property (p_lock_err) else $error("lock shown during error");
   property p_pump_up;
      s_test_run ##0 (lock_detect_out && !boost_out && $past(phase_pump_oe_n_out)) |-> phase_pump_up_out;
   endproperty
   a_pump_up: assert property (p_pump_up) else $error("reference lead not pumped up");
   property p_pump_down;
      s_test_run ##0 (boost_out && !lock_detect_out && $past(phase_pump_oe_n_out)) |-> phase_pump_down_out;
   endproperty
   a_pump_down: assert property (p_pump_down) else $error("feedback lead not pumped down");
endmodule // pdsc_top_sva
bind pdsc_top pdsc_top_sva i_sva (
   .ref_clk_in          (ref_clk_in),
   .reset_in            (reset_in),
   .battery_save_n_in   (battery_save_n_in),
   .fast_lock_control_in(fast_lock_control_in),
   .test_in             (test_in),
   .phase_pump_up_out   (phase_pump_up_out),
   .phase_pump_down_out (phase_pump_down_out),
   .phase_pump_oe_n_out (phase_pump_oe_n_out),
   .pump_boost_out      (pump_boost_out),
   .lock_detect_out     (lock_detect_out),
   .lock_detect_oe_n_out(lock_detect_oe_n_out),
   .boost_out           (boost_out)
);

// *** verif/pdsc_mcu_model.sv ***
// Controller model driving the three-wire programming port.
// Assumes the caller starts each word just after a ref_clk edge.
`timescale 1ns/10ps
module pdsc_mcu_model (
   // Serial port pins
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic ser_latch_en_out
);
   initial begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b0;
      ser_latch_en_out = 1'b0;
   end
   // 24 ns half period keeps data steady for several ref_clk cycles around each rise
   task automatic send(input logic [18:0] w);
      // Fractional offset keeps every pin change off a ref_clk sampling edge
      #0.2;
      for (int i = 18; i >= 0; i--) begin
         ser_data_out = w[i];
         #24 ser_clk_out = 1'b1;
         #24 ser_clk_out = 1'b0;
      end
      // Released data line sits at its pull-down level
      ser_data_out = 1'b0;
      #24 ser_latch_en_out = 1'b1;
      #48 ser_latch_en_out = 1'b0;
      #24;
   endtask
endmodule // pdsc_mcu_model

// *** verif/testbench.sv ***
// Bench: programs random divider words and measures the divide ratios.
// Assumes the test state routes divider pulses to the lock and boost pins.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; $display("BAD %s exp %0d got %0d", nm, e, a); end end
module testbench;
   logic        ref_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        ser_clk_in, ser_data_in, ser_latch_en_in;
   logic        divider_width_select_in = 1'b1;
   logic        battery_save_n_in = 1'b1;
   logic        fast_lock_control_in = 1'b0;
   logic        test_in = 1'b0;
   logic        ref_osc_in = 1'b0;
   logic        vco_in = 1'b0;
   logic        phase_pump_up_out, phase_pump_down_out, phase_pump_oe_n_out, pump_boost_out;
   logic        lock_detect_out, lock_detect_oe_n_out, boost_out;
   int          n_errors = 0;
   int          compares = 0;
   int          n_vco = 0;
   int          n_ref = 0;
   int          efb, eref, got, m, s, v, rg, le;
   logic [18:0] w;

   always #2.5 ref_clk_in = ~ref_clk_in;
   always #25 ref_osc_in = ~ref_osc_in;
   always #20 vco_in = ~vco_in;
   always @(posedge vco_in) n_vco++;
   always @(posedge ref_osc_in) n_ref++;

   pdsc_mcu_model i_mcu (
      .ser_clk_out     (ser_clk_in),
      .ser_data_out    (ser_data_in),
      .ser_latch_en_out(ser_latch_en_in)
   );
   pdsc_top i_dut (
      .ref_clk_in             (ref_clk_in),
      .reset_in               (reset_in),
      .ser_clk_in             (ser_clk_in),
      .ser_data_in            (ser_data_in),
      .ser_latch_en_in        (ser_latch_en_in),
      .divider_width_select_in(divider_width_select_in),
      .battery_save_n_in      (battery_save_n_in),
      .fast_lock_control_in   (fast_lock_control_in),
      .test_in                (test_in),
      .ref_osc_in             (ref_osc_in),
      .vco_in                 (vco_in),
      .phase_pump_up_out      (phase_pump_up_out),
      .phase_pump_down_out    (phase_pump_down_out),
      .phase_pump_oe_n_out    (phase_pump_oe_n_out),
      .pump_boost_out         (pump_boost_out),
      .lock_detect_out        (lock_detect_out),
      .lock_detect_oe_n_out   (lock_detect_oe_n_out),
      .boost_out              (boost_out)
   );

   function automatic int fb_ratio(int mm, int ss);
      return 32 * mm + ss;
   endfunction
   function automatic int ref_ratio(int vv, int rr);
      return (rr != 0) ? vv : vv * 8;
   endfunction
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // Edges between the 2nd and 3rd pulse; the first pulse may be cut short
   task automatic meas(input bit sel, output int n);
      int k = 0;
      int c0 = 0;
      logic p = 1'b1;
      logic q;
      n = 0;
      for (int i = 0; i < 40000 && k < 3; i++) begin
         cyc(1);
         q = sel ? lock_detect_out : boost_out;
         if (q === 1'b1 && p === 1'b0) begin
            k++;
            n = (sel ? n_ref : n_vco) - c0;
            c0 = sel ? n_ref : n_vco;
         end
         p = q;
      end
      if (k < 3) begin
         n_errors++;
         $display("BAD pulse wait exp 3 got %0d", k);
         report_and_stop();
      end
   endtask
   task automatic chk_ratios();
      cyc(1);
      test_in = 1'b1;
      meas(1'b0, got);
      `CHK("fb ratio", efb, got)
      meas(1'b1, got);
      `CHK("ref ratio", eref, got)
      `CHK("test lock oe_n", 1'b0, lock_detect_oe_n_out)
      cyc(1);
      test_in = 1'b0;
   endtask
   task automatic send_ref(input int tb, input int en);
      w = 19'((v << 4) | (en << 3) | (rg << 2) | (tb << 1) | 1);
      // Bits beyond the short register must fall out
      if (divider_width_select_in) w[18:17] = 2'($urandom);
      i_mcu.send(w);
   endtask

   initial begin
      void'($urandom(32'h596ef5df));
      cyc(4);
      reset_in = 1'b0;
      cyc(4);
      `CHK("lock oe_n", 1'b1, lock_detect_oe_n_out)
      for (int t = 0; t < 4; t++) begin
         divider_width_select_in = t[0];
         m = $urandom_range(5, 1);
         // Swallow at both ends of its range in two of the configurations
         s = (t == 1) ? 0 : (t == 2) ? m : $urandom_range(m, 0);
         rg = t[1];
         le = $urandom_range(1, 0);
         v = rg ? $urandom_range(60, 5) : $urandom_range(12, 5);
         w = 19'((m << 6) | (s << 1));
         if (t[0]) w[18:17] = 2'($urandom);
         i_mcu.send(w);
         send_ref(0, le);
         efb = fb_ratio(m, s);
         eref = ref_ratio(v, rg);
         chk_ratios();
         cyc(400);
         `CHK("lock oe_n", 1'(le == 0), lock_detect_oe_n_out)
         $display("config %0d done", t);
      end
      fast_lock_control_in = 1'b1;
      cyc(10);
      `CHK("pump boost", 1'b1, pump_boost_out)
      `CHK("boost", 1'b1, boost_out)
      fast_lock_control_in = 1'b0;
      cyc(10);
      `CHK("pump boost", 1'b0, pump_boost_out)
      `CHK("boost", 1'b0, boost_out)
      $display("fast lock done");
      battery_save_n_in = 1'b0;
      cyc(10);
      `CHK("pump oe_n", 1'b1, phase_pump_oe_n_out)
      send_ref(1, le);
      cyc(10);
      `CHK("test bit lock oe_n", 1'b0, lock_detect_oe_n_out)
      send_ref(0, 1);
      cyc(1);
      battery_save_n_in = 1'b1;
      chk_ratios();
      cyc(10);
      `CHK("lock oe_n", 1'b0, lock_detect_oe_n_out)
      $display("battery save done");
      reset_in = 1'b1;
      cyc(2);
      reset_in = 1'b0;
      cyc(4);
      `CHK("lock oe_n", 1'b1, lock_detect_oe_n_out)
      `CHK("pump oe_n", 1'b1, phase_pump_oe_n_out)
      $display("second reset done");
      report_and_stop();
   end
endmodule // testbench
